// file: rtl/fbw_pkg.sv
// Package: constants and carriers for the buffered-write flash host
package fbw_pkg;

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_BUF_SETUP  = 16'h00e8;
    localparam logic [15:0] CMD_CONFIRM    = 16'h00d0;
    localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
    localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;
    localparam logic [15:0] CMD_READ_STAT  = 16'h0070;

    // ------------------------------------------------------------
    // Limits and status fields
    // ------------------------------------------------------------
    localparam logic [8:0]  MAX_COUNT      = 9'h1ff;
    localparam int          READY_BIT      = 7;
    localparam int          SEQ_ERR_BIT    = 4;
    localparam int          PROG_ERR_BIT   = 4;
    localparam int          ERASE_ERR_BIT  = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          RESET_PULSE_NS = 100;
    localparam int          RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RESET_BUSY_US  = 25;
    localparam int          RESET_BUSY_CYC = (RESET_BUSY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          POWER_TO_RESET_RELEASE_TIME = 300;
    localparam int          POWER_RELEASE_CYC = POWER_TO_RESET_RELEASE_TIME;
    localparam int          BUS_PHASE_CYC  = 3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ceB;
        logic        oeB;
        logic        weB;
        logic        dqOeB;
        logic [23:0] addr;
        logic [15:0] dqOut;
    } fbw_bus_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic        fail;
        logic [15:0] status;
    } fbw_result_t;

endpackage : fbw_pkg

// file: rtl/fbw_bus_cycle.sv
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
module fbw_bus_cycle #(
    parameter int PHASE_CYC = fbw_pkg::BUS_PHASE_CYC
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    // Request
    input  wire logic          start,
    input  wire logic          isWrite,
    input  wire logic [23:0]   addr,
    input  wire logic [15:0]   wdata,
    // Answer
    output logic               done,
    output logic [15:0]        rdata,
    // Flash pins
    output fbw_pkg::fbw_bus_t  pins,
    input  wire logic [15:0]   dqSync
);
    typedef enum logic [1:0] {BC_IDLE, BC_ASSERT, BC_RELEASE} fbw_bc_state_t;
    typedef struct packed {
        fbw_bc_state_t     st;
        logic [7:0]        cnt;
        logic              done;
        logic [15:0]       rdata;
        fbw_pkg::fbw_bus_t pins;
    } fbw_bc_t;

    fbw_bc_t state_r;
    fbw_bc_t state_nxt;

    always_comb
    begin
        state_nxt      = state_r;
        state_nxt.done = 1'b0;
        case (state_r.st)
            BC_IDLE:
            begin
                if (start)
                begin
                    state_nxt.st         = BC_ASSERT;
                    state_nxt.cnt        = 8'h00;
                    state_nxt.pins.addr  = addr;
                    state_nxt.pins.dqOut = wdata;
                    state_nxt.pins.ceB   = 1'b0;
                    state_nxt.pins.weB   = ~isWrite;
                    state_nxt.pins.oeB   = isWrite;
                    state_nxt.pins.dqOeB = ~isWrite;
                end
            end
            BC_ASSERT:
            begin
                state_nxt.cnt = state_r.cnt + 8'h01;
                if (state_r.cnt == 8'(PHASE_CYC + 2))
                begin
                    state_nxt.rdata    = dqSync;
                    state_nxt.pins.ceB = 1'b1; // see R8
                    state_nxt.pins.oeB = 1'b1;
                    state_nxt.pins.weB = 1'b1;
                    state_nxt.st       = BC_RELEASE;
                    state_nxt.cnt      = 8'h00;
                end
            end
            default:
            begin
                state_nxt.cnt = state_r.cnt + 8'h01;
                if (state_r.cnt == 8'(PHASE_CYC))
                begin
                    state_nxt.pins.dqOeB = 1'b1;
                    state_nxt.done       = 1'b1;
                    state_nxt.st         = BC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_r       <= '0;
            state_r.st    <= BC_IDLE;
            state_r.pins  <= '{ceB: 1'b1, oeB: 1'b1, weB: 1'b1, dqOeB: 1'b1, addr: 24'h000000, dqOut: 16'h0000};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign done  = state_r.done;
    assign rdata = state_r.rdata;
    assign pins  = state_r.pins;
endmodule : fbw_bus_cycle

// file: rtl/fbw_flash_host.sv
// Host controller: buffered write sequence and reset driving for a parallel flash
//
// How it works
// R1: After setup, write word count minus one, 0000h to 01FFh.
// R2: During the sequence every read returns the status word.
// R3: Words are written from the start address upward.
// R4: Start addresses with bits 9:1 zero give best throughput.
// R5: Word addresses outside the start block make the device abort.
// R6: On abort the status flags a bad sequence; host sends clear-status.
// R7: Status is read right after the setup command.
// R8: Chip select is toggled between successive status reads.
// R9: Read-status command is never sent after setup.
// R10: After the last operation host writes FFh for read-array mode.
// R11: Full status check only after the sequence has completed.
// R12: Erase-to-suspend interval kept; this host issues no erase suspend.
// R13: While reset is low the device ignores its control pins.
// R14: Reset pin is held low at least 100 ns.
// R15: Reset during a program waits up to 25 us before access.
// R16: Reset while idle completes within the reset pulse time.
// R17: Reset held at least 300 units after power valid.
// R18: Reset pin follows the system reset through power transitions.
// R19: After reset the device is in read-array mode.
`timescale 1ns/1ps
module fbw_flash_host #(
    parameter int ADDR_W    = 24,
    parameter int BLOCK_LSB = 16,
    parameter int BUSY_CYC  = fbw_pkg::RESET_BUSY_CYC,
    parameter int POWER_CYC = fbw_pkg::POWER_RELEASE_CYC
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    // Command port
    input  wire logic               reqValid,
    input  wire logic [23:0]        reqAddr,
    input  wire logic [8:0]         reqCountM1,
    input  wire logic               resetReq,
    output logic                    reqReady,
    // Data words in
    input  wire logic [15:0]        wordData,
    output logic                    wordTake,
    // Result
    output fbw_pkg::fbw_result_t    result,
    // Flash pins
    output logic                    flashRst_b,
    output fbw_pkg::fbw_bus_t       flashBus,
    input  wire logic [15:0]        dqIn
);
    typedef enum logic [3:0] {
        S_POWER, S_RST_LOW, S_RST_WAIT, S_IDLE, S_SETUP, S_POLL_SETUP, S_COUNT,
        S_DATA, S_CONFIRM, S_POLL, S_CLEAR, S_ARRAY
    } fbw_state_t;

    typedef struct packed {
        fbw_state_t            st;
        logic [19:0]           cnt;
        logic [23:0]           addr;
        logic [8:0]            left;
        logic                  cycStart;
        logic                  cycWrite;
        logic [15:0]           cycData;
        logic                  rstOut;
        logic                  wordTake;
        logic                  reqReady;
        logic                  wasBusy;
        fbw_pkg::fbw_result_t  res;
    } fbw_host_t;

    fbw_host_t   state_r;
    fbw_host_t   state_nxt;
    logic [15:0] dqMeta_r;
    logic [15:0] dqSync_r;
    logic        cycDone;
    logic [15:0] cycRdata;

    function automatic logic sameBlock(input logic [23:0] a, input logic [23:0] b);
        sameBlock = (a[ADDR_W-1:BLOCK_LSB] == b[ADDR_W-1:BLOCK_LSB]);
    endfunction : sameBlock

    // ------------------------------------------------------------
    // Data pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        dqMeta_r <= dqIn;
        dqSync_r <= dqMeta_r;
    end

    fbw_bus_cycle i_fbw_bus_cycle (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .start   (state_r.cycStart),
        .isWrite (state_r.cycWrite),
        .addr    (state_r.addr),
        .wdata   (state_r.cycData),
        .done    (cycDone),
        .rdata   (cycRdata),
        .pins    (flashBus),
        .dqSync  (dqSync_r)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt          = state_r;
        state_nxt.cycStart = 1'b0;
        state_nxt.wordTake = 1'b0;
        state_nxt.res.done = 1'b0;
        case (state_r.st)
            S_POWER:
            begin
                state_nxt.cnt = state_r.cnt + 20'h00001;
                if (state_r.cnt >= 20'(POWER_CYC)) // see R17
                begin
                    state_nxt.st  = S_RST_LOW;
                    state_nxt.cnt = 20'h00000;
                end
            end
            S_RST_LOW:
            begin
                state_nxt.rstOut = 1'b0; // see R13
                state_nxt.cnt    = state_r.cnt + 20'h00001;
                if (state_r.cnt >= 20'(fbw_pkg::RESET_PULSE_CYC)) // see R14
                begin
                    state_nxt.rstOut = 1'b1;
                    state_nxt.st     = S_RST_WAIT;
                    state_nxt.cnt    = 20'h00000;
                end
            end
            S_RST_WAIT:
            begin
                state_nxt.cnt = state_r.cnt + 20'h00001;
                if (!state_r.wasBusy || state_r.cnt >= 20'(BUSY_CYC)) // see R15 R16
                begin
                    state_nxt.st       = S_IDLE; // see R19
                    state_nxt.wasBusy  = 1'b0;
                    state_nxt.res.busy = 1'b0;
                    state_nxt.reqReady = 1'b1;
                end
            end
            S_IDLE:
            begin
                if (resetReq)
                begin
                    state_nxt.st       = S_RST_LOW;
                    state_nxt.reqReady = 1'b0;
                    state_nxt.cnt      = 20'h00000;
                end
                else if (reqValid)
                begin
                    state_nxt.addr     = reqAddr; // see R3 R4
                    state_nxt.left     = (reqCountM1 > fbw_pkg::MAX_COUNT) ? fbw_pkg::MAX_COUNT : reqCountM1;
                    state_nxt.reqReady = 1'b0;
                    state_nxt.res.busy = 1'b1;
                    state_nxt.res.fail = 1'b0;
                    state_nxt.cycWrite = 1'b1;
                    state_nxt.cycData  = fbw_pkg::CMD_BUF_SETUP;
                    state_nxt.cycStart = 1'b1;
                    state_nxt.st       = S_SETUP;
                end
            end
            S_SETUP:
            begin
                if (cycDone)
                begin
                    state_nxt.cycWrite = 1'b0; // see R7 R9
                    state_nxt.cycStart = 1'b1;
                    state_nxt.st       = S_POLL_SETUP;
                end
            end
            S_POLL_SETUP:
            begin
                if (cycDone)
                begin
                    state_nxt.cycStart = 1'b1; // see R2 R8
                    if (cycRdata[fbw_pkg::READY_BIT])
                    begin
                        state_nxt.cycWrite = 1'b1;
                        state_nxt.cycData  = {7'h00, state_r.left}; // see R1
                        state_nxt.st       = S_COUNT;
                    end
                end
            end
            S_COUNT:
            begin
                if (cycDone)
                begin
                    state_nxt.wordTake = 1'b1;
                    state_nxt.cycData  = wordData;
                    state_nxt.cycStart = 1'b1;
                    state_nxt.st       = S_DATA;
                end
            end
            S_DATA:
            begin
                if (cycDone)
                begin
                    state_nxt.cycStart = 1'b1;
                    if (state_r.left == 9'h000)
                    begin
                        state_nxt.cycData = fbw_pkg::CMD_CONFIRM;
                        state_nxt.st      = S_CONFIRM;
                    end
                    else
                    begin
                        state_nxt.left     = state_r.left - 9'h001;
                        state_nxt.addr     = state_r.addr + 24'h000002;
                        state_nxt.wordTake = 1'b1;
                        state_nxt.cycData  = wordData;
                        if (!sameBlock(state_r.addr + 24'h000002, state_r.addr)) // see R5
                        begin
                            state_nxt.addr     = state_r.addr;
                            state_nxt.wordTake = 1'b0;
                            state_nxt.cycData = fbw_pkg::CMD_CONFIRM;
                            state_nxt.st      = S_CONFIRM;
                        end
                    end
                end
            end
            S_CONFIRM:
            begin
                if (cycDone)
                begin
                    state_nxt.cycWrite = 1'b0;
                    state_nxt.cycStart = 1'b1;
                    state_nxt.st       = S_POLL;
                end
            end
            S_POLL:
            begin
                if (cycDone)
                begin
                    state_nxt.cycStart = 1'b1; // see R8
                    if (cycRdata[fbw_pkg::READY_BIT]) // see R11 R12
                    begin
                        state_nxt.res.status = cycRdata;
                        state_nxt.cycWrite   = 1'b1;
                        if (cycRdata[fbw_pkg::SEQ_ERR_BIT] || cycRdata[fbw_pkg::ERASE_ERR_BIT])
                        begin
                            state_nxt.res.fail = 1'b1;
                            state_nxt.cycData  = fbw_pkg::CMD_CLR_STATUS; // see R6
                            state_nxt.st       = S_CLEAR;
                        end
                        else
                        begin
                            state_nxt.cycData = fbw_pkg::CMD_READ_ARRAY;
                            state_nxt.st      = S_ARRAY;
                        end
                    end
                end
            end
            S_CLEAR:
            begin
                if (cycDone)
                begin
                    state_nxt.cycData  = fbw_pkg::CMD_READ_ARRAY;
                    state_nxt.cycStart = 1'b1;
                    state_nxt.st       = S_ARRAY;
                end
            end
            default:
            begin
                if (cycDone) // see R10
                begin
                    state_nxt.res.busy = 1'b0;
                    state_nxt.res.done = 1'b1;
                    state_nxt.reqReady = 1'b1;
                    state_nxt.st       = S_IDLE;
                end
            end
        endcase
        if (resetReq && state_r.st != S_IDLE && state_r.st != S_POWER && state_r.st != S_RST_LOW)
        begin
            state_nxt.st       = S_RST_LOW; // see R15
            state_nxt.wasBusy  = (state_r.st >= S_CONFIRM);
            state_nxt.reqReady = 1'b0;
            state_nxt.cnt      = 20'h00000;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_r        <= '0; // see R18
            state_r.st     <= S_POWER;
            state_r.rstOut <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign reqReady   = state_r.reqReady;
    assign wordTake   = state_r.wordTake;
    assign result     = state_r.res;
    assign flashRst_b = state_r.rstOut;
endmodule : fbw_flash_host

// file: dv/fbw_host_properties.sv
// Checker: port-level properties of the flash host
`timescale 1ns/1ps
module fbw_host_properties #(
    parameter int ADDR_W    = 24,
    parameter int BLOCK_LSB = 16,
    parameter int BUSY_CYC  = 500,
    parameter int POWER_CYC = 300
) (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst_b,
    // Command port
    input wire logic                 reqValid,
    input wire logic [23:0]          reqAddr,
    input wire logic [8:0]           reqCountM1,
    input wire logic                 resetReq,
    input wire logic                 reqReady,
    // Data and result
    input wire logic [15:0]          wordData,
    input wire logic                 wordTake,
    input wire fbw_pkg::fbw_result_t result,
    // Flash pins
    input wire logic                 flashRst_b,
    input wire fbw_pkg::fbw_bus_t    flashBus,
    input wire logic [15:0]          dqIn
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    rst_width_a: assert property ($fell(flashRst_b) |-> !flashRst_b [*2])
        else $error("reset pulse too short");
    power_wait_a: assert property ($rose(rst_b) |-> !flashRst_b [*5])
        else $error("device reset released too early");
    reset_quiet_a: assert property (!flashRst_b && $past(!flashRst_b) |->
        flashBus.ceB && flashBus.weB && flashBus.oeB) else $error("strobes active in reset");
    req_take_a: assert property (reqValid && reqReady |=> !reqReady && result.busy)
        else $error("request not taken");
    setup_cmd_a: assert property (reqValid && reqReady |-> ##[2:8] (!flashBus.ceB &&
        !flashBus.weB && flashBus.dqOut == fbw_pkg::CMD_BUF_SETUP)) else $error("no setup write");
    write_drive_a: assert property (!flashBus.weB |-> !flashBus.dqOeB && !flashBus.ceB)
        else $error("write without data drive");
    read_toggle_a: assert property ($fell(flashBus.oeB) |-> $fell(flashBus.ceB) && flashBus.dqOeB)
        else $error("read without chip select toggle");
    done_pulse_a: assert property (result.done |=> !result.done)
        else $error("done longer than one cycle");
    busy_ready_a: assert property (result.busy |-> !reqReady)
        else $error("ready while busy");
endmodule : fbw_host_properties

bind fbw_flash_host fbw_host_properties #(.ADDR_W(ADDR_W), .BLOCK_LSB(BLOCK_LSB), .BUSY_CYC(BUSY_CYC),
    .POWER_CYC(POWER_CYC)) i_fbw_host_properties (.ref_clk(ref_clk), .rst_b(rst_b), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqCountM1(reqCountM1), .resetReq(resetReq), .reqReady(reqReady),
    .wordData(wordData), .wordTake(wordTake), .result(result), .flashRst_b(flashRst_b),
    .flashBus(flashBus), .dqIn(dqIn));

// file: dv/fbw_flash_model.sv
// Behavioural flash device: buffered write, status word and reset
`timescale 1ns/1ps
module fbw_flash_model #(
    parameter int BLOCK_LSB = 16
) (
    // Clock
    input wire logic              ref_clk,
    // Device pins
    input wire logic              flashRst_b,
    input wire fbw_pkg::fbw_bus_t bus,
    output logic [15:0]           dq
);
    logic [15:0] mem [logic [23:0]];
    logic [15:0] status = 16'h0080;
    logic [15:0] cmd, snap;
    logic [23:0] a, start;
    logic [8:0]  lastCount;
    logic        inArray = 1'b1, sawRdStat = 1'b0, sawClr = 1'b0, weP = 1'b1, selP = 1'b0;
    int          state = 0, left = 0, busyCnt = 0;
    initial dq = 16'h5a5a;
    always @(posedge ref_clk)
    begin
        if (!flashRst_b)
        begin
            inArray = 1'b1;
            state = 0;
            busyCnt = 0;
            status = 16'h0080;
            dq <= ~dq;
        end
        else
        begin
            if (busyCnt > 0)
            begin
                busyCnt--;
                status[7] = (busyCnt == 0);
            end
            if (!bus.weB && !bus.ceB)
            begin
                cmd = bus.dqOut;
                a = bus.addr;
            end
            if (!weP && bus.weB)
            begin
                if (state == 0)
                begin
                    if (cmd == fbw_pkg::CMD_BUF_SETUP)
                    begin
                        start = a;
                        state = 1;
                        inArray = 1'b0;
                    end
                    if (cmd == fbw_pkg::CMD_CLR_STATUS)
                    begin
                        status = 16'h0080;
                        sawClr = 1'b1;
                    end
                    if (cmd == fbw_pkg::CMD_READ_ARRAY)
                        inArray = 1'b1;
                end
                else if (state == 1)
                begin
                    sawRdStat |= (cmd == fbw_pkg::CMD_READ_STAT);
                    lastCount = cmd[8:0];
                    left = cmd[8:0] + 1;
                    state = 2;
                end
                else if (left == 0 || cmd == fbw_pkg::CMD_CONFIRM)
                begin
                    status[4] = status[4] | (left != 0) | (cmd != fbw_pkg::CMD_CONFIRM);
                    status[7] = 1'b0;
                    busyCnt = 8;
                    state = 0;
                end
                else
                begin
                    if (a[23:BLOCK_LSB] != start[23:BLOCK_LSB])
                        status[4] = 1'b1;
                    else
                        mem[a] = cmd;
                    left--;
                end
            end
            if (!bus.ceB && !bus.oeB)
            begin
                if (!selP)
                    snap = inArray ? (mem.exists(bus.addr) ? mem[bus.addr] : 16'hffff) : status;
                dq <= snap;
            end
            else
                dq <= ~dq;
        end
        weP = bus.weB;
        selP = !bus.ceB && !bus.oeB;
    end
endmodule : fbw_flash_model

// file: dv/testbench.sv
// Testbench: flash host against the behavioural flash model
`timescale 1ns/1ps
module testbench;
    logic                 ref_clk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, resetReq = 1'b0, takePrev = 1'b0;
    logic [23:0]          reqAddr = 24'h000000;
    logic [8:0]           reqCountM1 = 9'h000, wordIdx = 9'h000;
    logic                 reqReady, wordTake, flashRst_b;
    logic [15:0]          wordData, dqIn, modelDq;
    fbw_pkg::fbw_result_t result;
    fbw_pkg::fbw_bus_t    flashBus;
    int                   miscompares = 0, comparisons = 0;

    always #25 ref_clk = ~ref_clk;
    assign wordData = 16'h1000 + {7'h00, wordIdx};
    assign dqIn = flashBus.dqOeB ? modelDq : flashBus.dqOut;
    always @(negedge ref_clk)
    begin
        if (takePrev && !wordTake)
            wordIdx <= wordIdx + 9'h001;
        takePrev <= wordTake;
    end

    fbw_flash_host #(.BUSY_CYC(10), .POWER_CYC(4)) i_fbw_flash_host (.ref_clk(ref_clk), .rst_b(rst_b),
        .reqValid(reqValid), .reqAddr(reqAddr), .reqCountM1(reqCountM1), .resetReq(resetReq),
        .reqReady(reqReady), .wordData(wordData), .wordTake(wordTake), .result(result),
        .flashRst_b(flashRst_b), .flashBus(flashBus), .dqIn(dqIn));
    fbw_flash_model i_fbw_flash_model (.ref_clk(ref_clk), .flashRst_b(flashRst_b), .bus(flashBus), .dq(modelDq));

    task automatic check_bit(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check_bit

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s %h", $time, msg, got);
        end
    endtask : check_word

    task automatic wait_ready(output int n);
        n = 0;
        while (reqReady !== 1'b1 && n < 2000)
        begin
            @(negedge ref_clk);
            n++;
        end
        check_bit(reqReady, 1'b1, "ready");
    endtask : wait_ready

    task automatic run_write(input logic [23:0] a, input logic [8:0] c);
        int n;
        @(negedge ref_clk);
        reqAddr = a;
        reqCountM1 = c;
        reqValid = 1'b1;
        wordIdx = 9'h000;
        @(negedge ref_clk);
        reqValid = 1'b0;
        n = 0;
        while (result.done !== 1'b1 && n < 20000)
        begin
            @(negedge ref_clk);
            n++;
        end
        check_bit(result.done, 1'b1, "done");
    endtask : run_write

    task automatic t_power();
        int n;
        repeat (2) @(negedge ref_clk);
        check_bit(flashRst_b, 1'b0, "power wait");
        wait_ready(n);
        check_bit(flashRst_b, 1'b1, "reset release");
        check_bit(i_fbw_flash_model.inArray, 1'b1, "array after reset");
        $display("test power done");
    endtask : t_power

    task automatic t_program(input logic [23:0] a, input logic [8:0] c);
        int n;
        run_write(a, c);
        check_bit(result.fail, 1'b0, "fail");
        check_bit(result.status[7], 1'b1, "status ready");
        check_word({7'h00, i_fbw_flash_model.lastCount}, {7'h00, c}, "count");
        check_word(i_fbw_flash_model.mem[a], 16'h1000, "first word");
        check_word(i_fbw_flash_model.mem[a + {14'h0000, c, 1'b0}], 16'h1000 + {7'h00, c}, "last word");
        check_bit(i_fbw_flash_model.sawRdStat, 1'b0, "status cmd as count");
        check_bit(i_fbw_flash_model.inArray, 1'b1, "array mode");
        wait_ready(n);
        $display("test program done");
    endtask : t_program

    task automatic t_abort();
        int n;
        run_write(24'h00fffc, 9'h007);
        check_bit(result.fail, 1'b1, "abort flagged");
        check_bit(result.status[4], 1'b1, "sequence error");
        check_bit(i_fbw_flash_model.sawClr, 1'b1, "clear status");
        check_bit(1'(i_fbw_flash_model.mem.exists(24'h010000)), 1'b0, "crossing word");
        check_word({7'h00, wordIdx}, 16'h0002, "words taken");
        check_bit(i_fbw_flash_model.inArray, 1'b1, "array mode");
        wait_ready(n);
        $display("test abort done");
    endtask : t_abort

    task automatic t_reset(input bit midOp);
        int n, low;
        @(negedge ref_clk);
        if (midOp)
        begin
            reqAddr = 24'h000800;
            reqCountM1 = 9'h003;
            reqValid = 1'b1;
            wordIdx = 9'h000;
            @(negedge ref_clk);
            reqValid = 1'b0;
            n = 0;
            while (i_fbw_flash_model.busyCnt == 0 && n < 2000)
            begin
                @(negedge ref_clk);
                n++;
            end
        end
        resetReq = 1'b1;
        n = 0;
        while (flashRst_b !== 1'b0 && n < 50)
        begin
            @(negedge ref_clk);
            n++;
        end
        resetReq = 1'b0;
        low = 0;
        while (flashRst_b === 1'b0 && low < 50)
        begin
            @(negedge ref_clk);
            low++;
        end
        check_bit(low >= 2, 1'b1, "reset width");
        wait_ready(n);
        if (midOp)
            check_bit(low + n >= 10, 1'b1, "busy reset wait");
        else
            check_bit(low + n < 10, 1'b1, "idle reset wait");
        check_bit(i_fbw_flash_model.inArray, 1'b1, "array after reset");
        $display("test reset done");
    endtask : t_reset

    task final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        t_power();
        t_program(24'h000400, 9'h000);
        t_program(24'h020000, 9'h1ff);
        t_abort();
        t_reset(1'b0);
        t_reset(1'b1);
        final_report();
    end

    initial
    begin
        #(60000 * 50);
        miscompares++;
        final_report();
    end
endmodule : testbench
